// ---- src/swm_pkg.sv ----
// shared constants and types for the slave-node mode and wakeup control
package swm_pkg;

  // ****************************************
  // clocks and counter width
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 12;
  localparam int CNT_W = 16;

  // ****************************************
  // timing figures and derived cycle counts
  // ****************************************
  // mode-change time spent in standby
  localparam int MODE_CHG_US = 100;
  localparam int MODE_CHG_CYC = (MODE_CHG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // least bus low time taken as a wake pulse while asleep
  localparam int WAKE_DET_US = 250;
  localparam int WAKE_DET_CYC = (WAKE_DET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // transmit_low_trim_time removed from the front of a wake pulse
  localparam int TX_TRIM_US = 66;
  localparam int TX_TRIM_CYC = (TX_TRIM_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bus low stretch for a zero bit in normal mode
  localparam int ZERO_LOW_NS = 35000;
  localparam int ZERO_LOW_CYC = (ZERO_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // low width splitting a one bit from a zero bit at the receiver
  localparam int RX_SPLIT_NS = 26000;
  localparam int RX_SPLIT_CYC = (RX_SPLIT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  // ****************************************
  // reset values of synchronised pins
  // ****************************************
  localparam logic SLEEP_N_RST = 1'b0;
  localparam logic TXD_RST = 1'b1;
  localparam logic ROLE_RST = 1'b1;
  localparam logic BUS_RST = 1'b1;
  localparam logic LOW_RST = 1'b0;

  // ****************************************
  // operating states, one-hot
  // ****************************************
  typedef enum logic [4:0] {
    ST_SLEEP = 5'h01,
    ST_STANDBY = 5'h02,
    ST_NORMAL = 5'h04,
    ST_WAKE_PULSE = 5'h08,
    ST_THERMAL = 5'h10
  } swm_state_t;

endpackage

// ---- src/swm_sync.sv ----
// two flip-flop synchroniser for one level
`timescale 1ns/1ps

module swm_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_d,
  output logic o_q
);

  logic meta_reg;
  logic stable_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST_VAL;
      stable_reg <= RST_VAL;
    end else begin
      meta_reg <= i_d;
      stable_reg <= meta_reg;
    end
  end

  assign o_q = stable_reg;

endmodule

// ---- src/swm_rx_decoder.sv ----
// link-clock receive decoder: bit value from low width and recovered baud clock
`timescale 1ns/1ps

module swm_rx_decoder
  import swm_pkg::*;
#(
  parameter int SPLIT_CYCLES = RX_SPLIT_CYC
) (
  input wire logic i_link_clk,
  input wire logic i_link_rst_n,
  input wire logic i_bus_rx,
  input wire logic i_enable,
  output logic o_rx_data,
  output logic o_rec_clk
);

  logic bus_s;
  logic en_s;
  logic bus_q_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic rx_data_reg;
  logic rec_clk_reg;
  logic low_short;

  swm_sync #(.RST_VAL(BUS_RST)) u_bus_sync (
    .i_clk(i_link_clk),
    .i_rst_n(i_link_rst_n),
    .i_d(i_bus_rx),
    .o_q(bus_s)
  );

  swm_sync #(.RST_VAL(LOW_RST)) u_en_sync (
    .i_clk(i_link_clk),
    .i_rst_n(i_link_rst_n),
    .i_d(i_enable),
    .o_q(en_s)
  );

  assign low_short = low_cnt_reg < CNT_W'(SPLIT_CYCLES);

  always_ff @(posedge i_link_clk or negedge i_link_rst_n) begin
    if (!i_link_rst_n) begin
      bus_q_reg <= BUS_RST;
    end else begin
      bus_q_reg <= bus_s;
    end
  end

  // low width counter, saturating so a stuck bus cannot wrap into a one
  always_ff @(posedge i_link_clk or negedge i_link_rst_n) begin
    if (!i_link_rst_n) begin
      low_cnt_reg <= '0;
    end else if (!en_s || bus_s) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg != {CNT_W{1'b1}}) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  // decoded bit is known only at the rising edge, so rx data changes at the end of each bit's low
  always_ff @(posedge i_link_clk or negedge i_link_rst_n) begin
    if (!i_link_rst_n) begin
      rx_data_reg <= 1'b1;
    end else if (!en_s) begin
      rx_data_reg <= 1'b1;
    end else if (!bus_q_reg && bus_s) begin
      rx_data_reg <= low_short; // R11
    end
  end

  // recovered clock: low after each falling edge until the bus rises or the split time runs out
  always_ff @(posedge i_link_clk or negedge i_link_rst_n) begin
    if (!i_link_rst_n) begin
      rec_clk_reg <= 1'b1;
    end else begin
      rec_clk_reg <= !en_s || bus_s || !low_short; // R23
    end
  end

  assign o_rx_data = rx_data_reg;
  assign o_rec_clk = rec_clk_reg;

endmodule

// ---- src/swm_mode_ctrl.sv ----
// slave-node mode control, sleep pass-through, wake pulse and thermal shutdown
//
// What this block does and what the host must do
// (R01) After reset the block starts in Sleep before any other state.
// (R02) Sleep processing or bus error returns Normal to Sleep; only bus error returns Standby to Sleep.
// (R03) In Sleep, a local cause or bus wake pulse moves to Standby.
// (R04) Sleep is entered on falling sleep control while transmit is high.
// (R05) In Normal the bus transmit path is disabled as soon as sleep control is low.
// (R06) Host holds every wake event stable for the mode-change time.
// (R07) Before sleep control falls: transmit, role high, pins released high.
// (R08) Before sleep control rises: transmit, role high, pins released high.
// (R09) In slave Sleep the raw bus level is driven out on the clock pin.
// (R10) In Sleep the receive data pin is held driven high.
// (R11) In Normal the bus is decoded and given out as serial data.
// (R12) In slave Sleep, transmit low with sleep control low is forwarded to the bus unencoded.
// (R13) Wake pulse width is transmit low time minus the trim time.
// (R14) Host may send an all-zero byte at the lower rate for wake.
// (R15) At the highest rate host holds transmit low beyond 466 microseconds.
// (R16) Standby is reached only from Sleep.
// (R17) Standby releases clock, receive and bus pins and moves no data.
// (R18) Standby moves to Normal once the mode-change time has run out.
// (R19) Host keeps sleep control low at power-up until supply is good.
// (R20) Overtemperature disables the bus output driver.
// (R21) Driver returns only after cooling and a transmit toggle by the host.
// (R22) Host keeps role select high and steady in Normal and wake pulse.
// (R23) In slave Normal the recovered baud clock goes out on the clock pin.
// (R24) Overtemperature protection is inactive in Sleep.
// (R25) Exactly one of five operating states is active at any time.
`timescale 1ns/1ps

module swm_mode_ctrl
  import swm_pkg::*;
#(
  parameter int MODE_CHG_CYCLES = MODE_CHG_CYC,
  parameter int WAKE_DET_CYCLES = WAKE_DET_CYC,
  parameter int TRIM_CYCLES = TX_TRIM_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_LINK_CLK,
  input wire logic I_SLEEP_CONTROL_N,
  input wire logic I_TXD,
  input wire logic I_ROLE_SELECT,
  input wire logic I_LOCAL_WAKE,
  input wire logic I_BUS_ERROR,
  input wire logic I_OVERTEMP,
  input wire logic I_BUS_RX,
  output logic O_BUS_OUT,
  output logic O_BUS_OE_N,
  output logic O_CLK_OUT,
  output logic O_CLK_OE_N,
  output logic O_RXD_OUT,
  output logic O_RXD_OE_N,
  output logic [4:0] O_STATE
);

  // ****************************************
  // reset release in both domains
  // ****************************************
  logic [1:0] rst_pipe_reg;
  logic [1:0] link_rst_pipe_reg;
  logic rst_n;
  logic link_rst_n;

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  always_ff @(posedge I_LINK_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      link_rst_pipe_reg <= 2'h0;
    end else begin
      link_rst_pipe_reg <= {link_rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe_reg[1];
  assign link_rst_n = link_rst_pipe_reg[1];

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic sleep_n_s;
  logic txd_s;
  logic role_s;
  logic local_wake_s;
  logic overtemp_s;
  logic bus_s;
  logic rx_data_s;
  logic rec_clk_s;
  logic rx_data_link;
  logic rec_clk_link;
  logic link_enable_reg;

  swm_sync #(.RST_VAL(SLEEP_N_RST)) u_sleep_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_d(I_SLEEP_CONTROL_N),
    .o_q(sleep_n_s)
  );

  swm_sync #(.RST_VAL(TXD_RST)) u_txd_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_d(I_TXD),
    .o_q(txd_s)
  );

  swm_sync #(.RST_VAL(ROLE_RST)) u_role_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_d(I_ROLE_SELECT),
    .o_q(role_s)
  );

  swm_sync #(.RST_VAL(LOW_RST)) u_wake_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_d(I_LOCAL_WAKE),
    .o_q(local_wake_s)
  );

  swm_sync #(.RST_VAL(LOW_RST)) u_temp_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_d(I_OVERTEMP),
    .o_q(overtemp_s)
  );

  // sleep pass-through runs on the system clock: the link clock is not needed in sleep
  swm_sync #(.RST_VAL(BUS_RST)) u_bus_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_d(I_BUS_RX),
    .o_q(bus_s)
  );

  swm_sync #(.RST_VAL(BUS_RST)) u_rxd_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_d(rx_data_link),
    .o_q(rx_data_s)
  );

  swm_sync #(.RST_VAL(BUS_RST)) u_rclk_sync (
    .i_clk(I_CLK),
    .i_rst_n(rst_n),
    .i_d(rec_clk_link),
    .o_q(rec_clk_s)
  );

  // ****************************************
  // link-domain decoder
  // ****************************************
  swm_rx_decoder u_decoder (
    .i_link_clk(I_LINK_CLK),
    .i_link_rst_n(link_rst_n),
    .i_bus_rx(I_BUS_RX),
    .i_enable(link_enable_reg),
    .o_rx_data(rx_data_link),
    .o_rec_clk(rec_clk_link)
  );

  // ****************************************
  // edges and events
  // ****************************************
  logic sleep_n_q_reg;
  logic bus_q_reg;
  logic sleep_fall;
  logic bus_fall;
  logic ot_active;
  logic bus_wake;

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sleep_n_q_reg <= SLEEP_N_RST;
      bus_q_reg <= BUS_RST;
    end else begin
      sleep_n_q_reg <= sleep_n_s;
      bus_q_reg <= bus_s;
    end
  end

  assign sleep_fall = sleep_n_q_reg && !sleep_n_s && txd_s; // R04 R07
  assign bus_fall = bus_q_reg && !bus_s;

  // ****************************************
  // operating state
  // ****************************************
  swm_state_t state_reg;
  swm_state_t state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic from_wake_reg;
  logic txd_seen_low_reg;
  logic recovered;

  assign ot_active = overtemp_s && (state_reg != ST_SLEEP); // R24
  assign bus_wake = cnt_reg >= CNT_W'(WAKE_DET_CYCLES);
  assign recovered = !overtemp_s && txd_seen_low_reg && txd_s; // R21

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SLEEP: begin
        if (sleep_n_s || local_wake_s || (bus_wake && !bus_s)) begin
          state_next = ST_STANDBY; // R03 R08
        end else if (!txd_s && role_s) begin
          state_next = ST_WAKE_PULSE; // R12
        end
      end
      ST_STANDBY: begin
        if (I_BUS_ERROR) begin
          state_next = ST_SLEEP; // R02
        end else if (cnt_reg >= CNT_W'(MODE_CHG_CYCLES)) begin
          state_next = ST_NORMAL; // R18
        end
      end
      ST_NORMAL: begin
        if (I_BUS_ERROR || sleep_fall) begin
          state_next = ST_SLEEP; // R02
        end else if (ot_active) begin
          state_next = ST_THERMAL; // R20
        end
      end
      ST_WAKE_PULSE: begin
        if (ot_active) begin
          state_next = ST_THERMAL; // R20
        end else if (txd_s) begin
          state_next = ST_SLEEP;
        end
      end
      ST_THERMAL: begin
        if (I_BUS_ERROR || sleep_fall) begin
          state_next = ST_SLEEP;
        end else if (recovered) begin
          state_next = from_wake_reg ? ST_SLEEP : ST_NORMAL; // R21
        end
      end
      default: begin
        state_next = ST_SLEEP; // R25
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_SLEEP; // R01
    end else begin
      state_reg <= state_next; // R16
    end
  end

  // one counter serves bus-low timing in sleep, standby timing and wake trim
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (state_next != state_reg) begin
      cnt_reg <= '0;
    end else if ((state_reg == ST_SLEEP) && bus_s) begin
      cnt_reg <= '0;
    end else if ((state_reg == ST_NORMAL) || (state_reg == ST_THERMAL)) begin
      cnt_reg <= '0;
    end else if (cnt_reg != {CNT_W{1'b1}}) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      from_wake_reg <= 1'b0;
    end else if ((state_next == ST_THERMAL) && (state_reg != ST_THERMAL)) begin
      from_wake_reg <= (state_reg == ST_WAKE_PULSE);
    end
  end

  // a toggle counts only once the die has cooled; a stale low from before does not
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      txd_seen_low_reg <= 1'b0;
    end else if ((state_reg == ST_THERMAL) && !overtemp_s && !txd_s) begin
      txd_seen_low_reg <= 1'b1; // R21
    end else if (state_reg != ST_THERMAL) begin
      txd_seen_low_reg <= 1'b0;
    end
  end

  // ****************************************
  // normal-mode transmit encoding
  // ****************************************
  logic stretch_reg;
  logic [CNT_W-1:0] stretch_cnt_reg;

  // a zero bit holds the bus low past the master's short one-bit low
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      stretch_reg <= 1'b0;
      stretch_cnt_reg <= '0;
    end else if (state_reg != ST_NORMAL) begin
      stretch_reg <= 1'b0;
      stretch_cnt_reg <= '0;
    end else if (bus_fall && !txd_s) begin
      stretch_reg <= 1'b1;
      stretch_cnt_reg <= '0;
    end else if (stretch_reg) begin
      stretch_cnt_reg <= stretch_cnt_reg + 1'b1;
      if (stretch_cnt_reg >= CNT_W'(ZERO_LOW_CYC - 1)) begin
        stretch_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  logic bus_drive_reg;
  logic clk_out_reg;
  logic clk_oe_n_reg;
  logic rxd_out_reg;
  logic rxd_oe_n_reg;
  logic wake_drive;
  logic normal_drive;
  logic sleeping;
  logic running;

  assign sleeping = (state_reg == ST_SLEEP) || (state_reg == ST_WAKE_PULSE);
  assign running = (state_reg == ST_NORMAL) || (state_reg == ST_THERMAL);
  assign wake_drive = (state_reg == ST_WAKE_PULSE) && !txd_s && !ot_active
    && (cnt_reg >= CNT_W'(TRIM_CYCLES)); // R13
  assign normal_drive = (state_reg == ST_NORMAL) && stretch_reg && sleep_n_s && !ot_active; // R05

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_drive_reg <= 1'b0;
    end else begin
      bus_drive_reg <= wake_drive || normal_drive; // R12
    end
  end

  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      link_enable_reg <= 1'b0;
    end else begin
      link_enable_reg <= running;
    end
  end

  // clock pin: raw bus in sleep, recovered clock when running; master role keeps it an input
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_reg <= 1'b1;
      clk_oe_n_reg <= 1'b1;
    end else if (!role_s) begin
      clk_out_reg <= 1'b1;
      clk_oe_n_reg <= 1'b1;
    end else if (sleeping) begin
      clk_out_reg <= bus_s; // R09
      clk_oe_n_reg <= 1'b0;
    end else if (running) begin
      clk_out_reg <= rec_clk_s; // R23
      clk_oe_n_reg <= 1'b0;
    end else begin
      clk_out_reg <= 1'b1; // R17
      clk_oe_n_reg <= 1'b1;
    end
  end

  // receive pin stays high in sleep so short raw lows never reach the host
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rxd_out_reg <= 1'b1;
      rxd_oe_n_reg <= 1'b0;
    end else if (sleeping) begin
      rxd_out_reg <= 1'b1; // R10
      rxd_oe_n_reg <= 1'b0;
    end else if (running) begin
      rxd_out_reg <= rx_data_s; // R11
      rxd_oe_n_reg <= 1'b0;
    end else begin
      rxd_out_reg <= 1'b1; // R17
      rxd_oe_n_reg <= 1'b1;
    end
  end

  assign O_BUS_OUT = 1'b0;
  assign O_BUS_OE_N = !bus_drive_reg; // R20
  assign O_CLK_OUT = clk_out_reg;
  assign O_CLK_OE_N = clk_oe_n_reg;
  assign O_RXD_OUT = rxd_out_reg;
  assign O_RXD_OE_N = rxd_oe_n_reg;
  assign O_STATE = state_reg; // R25

endmodule

// ---- testbench/swm_mode_ctrl_checker.sv ----
// port-level assertions for the mode control block
`timescale 1ns/1ps

module swm_mode_ctrl_checker #(
  parameter int MODE_CHG_CYCLES = 20,
  parameter int TRIM_CYCLES = 10
) (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_BUS_RX,
  input wire logic O_BUS_OE_N,
  input wire logic O_CLK_OUT,
  input wire logic O_CLK_OE_N,
  input wire logic O_RXD_OUT,
  input wire logic O_RXD_OE_N,
  input wire logic [4:0] O_STATE
);
  int stby_cnt;
  int wk_cnt;
  int age;
  int slp_cnt;

  // age masks the pin-sync settling right after reset release
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      stby_cnt <= 0;
      wk_cnt <= 0;
      age <= 0;
      slp_cnt <= 0;
    end else begin
      slp_cnt <= (O_STATE == 5'h01 || O_STATE == 5'h08) ? slp_cnt + 1 : 0;
      stby_cnt <= (O_STATE == 5'h02) ? stby_cnt + 1 : 0;
      wk_cnt <= (O_STATE == 5'h08) ? wk_cnt + 1 : 0;
      if (age < 15) age <= age + 1;
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  a_state_one_hot: assert property ($onehot(O_STATE)) else $error("state not one-hot");
  a_standby_from_sleep: assert property ((O_STATE == 5'h02 && $past(O_STATE) != 5'h02) |->
    $past(O_STATE) == 5'h01) else $error("standby entered from wrong state");
  // pin drivers are registered, so they settle one cycle after the state
  a_standby_released: assert property ((O_STATE == 5'h02 && $past(O_STATE) == 5'h02) |->
    O_CLK_OE_N && O_RXD_OE_N && O_BUS_OE_N) else $error("pin driven in standby");
  a_standby_bounded: assert property (O_STATE == 5'h02 |-> stby_cnt <= MODE_CHG_CYCLES + 2)
    else $error("standby overstayed");
  a_normal_after_wait: assert property ((O_STATE == 5'h04 && stby_cnt != 0) |-> stby_cnt >= MODE_CHG_CYCLES)
    else $error("standby left early");
  a_sleep_rxd_high: assert property ((O_STATE == 5'h01 && $past(O_STATE) == 5'h01) |->
    !O_RXD_OE_N && O_RXD_OUT) else $error("receive pin not high in sleep");
  // every cycle in between must be asleep: a short standby would leave the clock pin released
  a_sleep_pass_clk: assert property ((age > 8 && O_STATE == 5'h01 && slp_cnt >= 4) |->
    !O_CLK_OE_N && O_CLK_OUT == $past(I_BUS_RX, 3)) else $error("clock pin not following bus");
  a_thermal_bus_off: assert property ((O_STATE == 5'h10 && $past(O_STATE) == 5'h10) |-> O_BUS_OE_N)
    else $error("bus driven in thermal shutdown");
  a_sleep_no_thermal: assert property ($past(O_STATE) == 5'h01 |-> O_STATE != 5'h10)
    else $error("thermal entered from sleep");
  a_bus_drive_state: assert property (!O_BUS_OE_N |-> O_STATE == 5'h04 || O_STATE == 5'h08)
    else $error("bus driven outside normal or wake");
  a_wake_trim_quiet: assert property ((O_STATE == 5'h08 && wk_cnt < TRIM_CYCLES) |-> O_BUS_OE_N)
    else $error("wake pulse not trimmed");
  a_wake_drive_on: assert property ((O_STATE == 5'h08 && wk_cnt == TRIM_CYCLES + 3) |-> !O_BUS_OE_N)
    else $error("wake pulse not driven");
endmodule

bind swm_mode_ctrl swm_mode_ctrl_checker #(.MODE_CHG_CYCLES(MODE_CHG_CYCLES), .TRIM_CYCLES(TRIM_CYCLES)) u_chk (
  .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_BUS_RX(I_BUS_RX), .O_BUS_OE_N(O_BUS_OE_N), .O_CLK_OUT(O_CLK_OUT),
  .O_CLK_OE_N(O_CLK_OE_N), .O_RXD_OUT(O_RXD_OUT), .O_RXD_OE_N(O_RXD_OE_N), .O_STATE(O_STATE));

// ---- testbench/swm_host_model.sv ----
// host controller model driving the sleep, transmit and role pins
`timescale 1ns/1ps

module swm_host_model (
  input wire logic i_clk,
  output logic o_sleep_control_n,
  output logic o_txd,
  output logic o_role_select
);
  initial begin
    o_sleep_control_n = 1'b0;
    o_txd = 1'b1;
    o_role_select = 1'b1;
  end

  task automatic set_pins(input logic sn, input logic txd, input int hold);
    @(posedge i_clk);
    o_sleep_control_n <= sn;
    o_txd <= txd;
    repeat (hold) @(posedge i_clk);
  endtask

  // transmit parked high before either sleep edge
  task automatic release_sleep();
    set_pins(1'b0, 1'b1, 3);
    set_pins(1'b1, 1'b1, 0);
  endtask

  task automatic enter_sleep();
    set_pins(1'b1, 1'b1, 3);
    set_pins(1'b0, 1'b1, 0);
  endtask

  // low on transmit while asleep; caller raises it again
  task automatic wake_pulse(input int n);
    set_pins(1'b0, 1'b0, n);
  endtask
endmodule

// ---- testbench/swm_mode_ctrl_tb_top.sv ----
// self-checking bench for the mode control block
`timescale 1ns/1ps

module swm_mode_ctrl_tb_top;
  import swm_pkg::*;
  localparam int MCC = 20;
  localparam int TRC = 10;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic local_wake = 1'b0;
  logic bus_error = 1'b0;
  logic overtemp = 1'b0;
  logic far_low = 1'b0;
  wire sleep_n, txd, role, bus_rx, bus_out, bus_oe_n, clk_out, clk_oe_n, rxd_out, rxd_oe_n;
  wire [4:0] state;
  int fail_count = 0;
  int checked = 0;
  int waited = 0;
  int cyc = 0;
  int low_run = 0;
  int last_run = 0;
  logic [7:0] byte_v;
  int exp_q[$];

  always #5 clk = ~clk;
  always #6 link_clk = ~link_clk;
  // bus has a pull-up; either party may pull it low
  assign bus_rx = ~far_low & (bus_oe_n | bus_out);

  swm_host_model host (.i_clk(clk), .o_sleep_control_n(sleep_n), .o_txd(txd), .o_role_select(role));

  swm_mode_ctrl #(.MODE_CHG_CYCLES(MCC), .WAKE_DET_CYCLES(30), .TRIM_CYCLES(TRC)) DUT (
    .I_CLK(clk), .I_RESETN(resetn), .I_LINK_CLK(link_clk), .I_SLEEP_CONTROL_N(sleep_n), .I_TXD(txd),
    .I_ROLE_SELECT(role), .I_LOCAL_WAKE(local_wake), .I_BUS_ERROR(bus_error), .I_OVERTEMP(overtemp),
    .I_BUS_RX(bus_rx), .O_BUS_OUT(bus_out), .O_BUS_OE_N(bus_oe_n), .O_CLK_OUT(clk_out),
    .O_CLK_OE_N(clk_oe_n), .O_RXD_OUT(rxd_out), .O_RXD_OE_N(rxd_oe_n), .O_STATE(state));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!bus_oe_n) low_run <= low_run + 1;
    else if (low_run != 0) begin
      last_run <= low_run;
      low_run <= 0;
    end
    if (cyc == 90000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp_state(input logic [4:0] exp);
    checked++;
    if (state !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, state, exp);
    end
  endtask

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_state(input logic [4:0] exp, input int lim);
    #1;
    waited = 0;
    while (state !== exp && waited < lim) begin
      @(posedge clk);
      #1;
      waited++;
    end
    cmp_state(exp);
    // hand back on an edge so the next stimulus lands on it
    @(posedge clk);
  endtask

  task automatic bus_low(input int n);
    @(posedge clk);
    far_low <= 1'b1;
    repeat (n) @(posedge clk);
    far_low <= 1'b0;
  endtask

  task automatic pulse_error();
    @(posedge clk);
    bus_error <= 1'b1;
    @(posedge clk);
    bus_error <= 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(61300));
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (10) @(posedge clk);
    wait_state(5'h01, 0);
    repeat (3) begin
      bus_low(5 + $urandom % 20);
      repeat (10) @(posedge clk);
    end
    wait_state(5'h01, 0);
    overtemp <= 1'b1;
    repeat (20) @(posedge clk);
    wait_state(5'h01, 0);
    overtemp <= 1'b0;
    host.wake_pulse(20);
    wait_state(5'h08, 0);
    host.set_pins(1'b0, 1'b1, 10);
    wait_state(5'h01, 10);
    cmp_val(16'(last_run >= 8 && last_run <= 14), 16'h1);
    local_wake <= 1'b1;
    wait_state(5'h02, 20);
    wait_state(5'h04, 40);
    cmp_val(16'(waited >= MCC - 1 && waited <= MCC + 3), 16'h1);
    local_wake <= 1'b0;
    // byte frame: each bit opens with a bus low, short low for one
    byte_v = 8'($urandom);
    exp_q = {0};
    for (int i = 0; i < 8; i++) exp_q.push_back(int'(byte_v[i]));
    exp_q.push_back(1);
    foreach (exp_q[i]) begin
      bus_low(exp_q[i] ? 1000 : 3500);
      repeat (50) @(posedge clk);
      #1;
      cmp_val(16'(rxd_out), 16'(exp_q[i]));
      repeat (1400 + (exp_q[i] ? 2500 : 0)) @(posedge clk);
      far_low <= 1'b1;
      repeat (100) @(posedge clk);
      #1;
      cmp_val({clk_oe_n, clk_out}, 16'h0);
      @(posedge clk);
      far_low <= 1'b0;
      repeat (200) @(posedge clk);
    end
    pulse_error();
    wait_state(5'h01, 10);
    bus_low(40);
    wait_state(5'h02, 20);
    pulse_error();
    wait_state(5'h01, 10);
    repeat (30) @(posedge clk);
    wait_state(5'h01, 0);
    host.release_sleep();
    wait_state(5'h04, 60);
    // transmit low in normal: a bus fall is stretched into a zero bit
    host.set_pins(1'b1, 1'b0, 3);
    bus_low(5);
    repeat (20) @(posedge clk);
    #1;
    cmp_val(16'(bus_oe_n), 16'h0);
    // sleep control low cuts the stretch at once, and the fall is refused with transmit low
    host.set_pins(1'b0, 1'b0, 10);
    #1;
    cmp_val(16'(bus_oe_n), 16'h1);
    wait_state(5'h04, 0);
    host.enter_sleep();
    wait_state(5'h01, 20);
    host.release_sleep();
    wait_state(5'h04, 60);
    overtemp <= 1'b1;
    wait_state(5'h10, 20);
    overtemp <= 1'b0;
    repeat (20) @(posedge clk);
    wait_state(5'h10, 0);
    host.set_pins(1'b1, 1'b0, 5);
    host.set_pins(1'b1, 1'b1, 5);
    wait_state(5'h04, 20);
    stop_test();
  end
endmodule
